// *** design/sfpe_pkg.sv ***
// shared constants for the serial flash program and erase link
package sfpe_pkg;
   // command codes
   localparam logic [7:0] OP_WRITE_EN = 8'h06;
   localparam logic [7:0] OP_READ_STAT = 8'h05;
   localparam logic [7:0] OP_QUAD_PROG = 8'h32;
   localparam logic [7:0] OP_QUAD_PROG_A4 = 8'h34;
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_4K_A4 = 8'h21;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hd8;
   localparam logic [7:0] OP_ERASE_64K_A4 = 8'hdc;
   // frame layout in link clock edges
   localparam logic [5:0] OP_EDGES = 6'h08;
   localparam logic [5:0] ADDR3_EDGES = 6'h18;
   localparam logic [5:0] ADDR4_EDGES = 6'h20;
   localparam logic [5:0] EDGE_CNT_MAX = 6'h3f;
   localparam logic [3:0] STAT_EDGES = 4'h8;
   // memory geometry
   localparam int ADDR_W = 26;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam logic [10:0] BLOCKS_64K = 11'h400;
   localparam logic [3:0] PROT_RANGE_CAP = 4'hb;
   // status byte positions
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_LATCH_POS = 1;
   // erase unit size codes
   localparam logic [1:0] SIZE_4K = 2'h0;
   localparam logic [1:0] SIZE_32K = 2'h1;
   localparam logic [1:0] SIZE_64K = 2'h2;
   // self-timed cycle lengths
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned PAGE_PROG_TIME_US = 700;
   localparam int unsigned SECTOR_ERASE_TIME_US = 50000;
   localparam int unsigned HALF_BLOCK_ERASE_TIME_US = 150000;
   localparam int unsigned BLOCK_ERASE_TIME_US = 200000;
   // host link clock half period in system clocks
   localparam logic [2:0] HOST_HALF_CYCLES = 3'h4;
endpackage

// *** design/sfpe_link_if.sv ***
// serial link between the flash device end and the host controller end
`timescale 1ns/10ps
`default_nettype none
interface sfpe_link_if;
   logic cs_n;
   logic sck;
   logic [3:0] host_io_o;
   logic [3:0] host_io_oe;
   logic [3:0] dev_io_o;
   logic [3:0] dev_io_oe;
   logic [3:0] io;

   //==========================================================
   // pin resolution, weak pull-up when nobody drives
   genvar g;
   for (g = 0; g < 4; g++)
   begin : g_pin
      assign io[g] = host_io_oe[g] ? host_io_o[g] :
                     (dev_io_oe[g] ? dev_io_o[g] : 1'b1);
   end

   modport host (output cs_n, output sck, output host_io_o,
                 output host_io_oe, input io);
   modport dev (input cs_n, input sck, input io,
                output dev_io_o, output dev_io_oe);
endinterface
`default_nettype wire

// *** design/sfpe_flash_dev.sv ***
// flash device end: quad page program, erase, write enable, status
`timescale 1ns/10ps
`default_nettype none
module sfpe_flash_dev #(
   parameter int unsigned PROG_CYCLES =
      sfpe_pkg::PAGE_PROG_TIME_US * sfpe_pkg::CLK_MHZ,
   parameter int unsigned SECTOR_CYCLES =
      sfpe_pkg::SECTOR_ERASE_TIME_US * sfpe_pkg::CLK_MHZ,
   parameter int unsigned HALF_BLOCK_CYCLES =
      sfpe_pkg::HALF_BLOCK_ERASE_TIME_US * sfpe_pkg::CLK_MHZ,
   parameter int unsigned BLOCK_CYCLES =
      sfpe_pkg::BLOCK_ERASE_TIME_US * sfpe_pkg::CLK_MHZ
)(
   input wire logic I_MCLK,
   input wire logic I_RST,
   sfpe_link_if.dev LNK,
   input wire logic I_ADDR4_MODE,
   input wire logic I_QUAD_IO_ENABLE_BIT,
   input wire logic [3:0] I_PROTECT_RANGE_BITS,
   input wire logic I_PROTECT_TOP_BOTTOM_BIT,
   input wire logic I_PROTECT_COMPLEMENT_BIT,
   input wire logic I_LOCK_HIT,
   output logic O_BUSY,
   output logic O_WRITE_LATCH_BIT,
   output logic [sfpe_pkg::ADDR_W-1:0] O_TARGET_ADDR,
   output logic O_PROG_WE,
   output logic [sfpe_pkg::ADDR_W-1:0] O_PROG_ADDR,
   output logic [7:0] O_PROG_DATA,
   output logic O_ERASE_REQ,
   output logic [1:0] O_ERASE_SIZE,
   output logic O_REJECT
);
   typedef enum logic [1:0] {DS_IDLE, DS_CHECK, DS_RUN} sfpe_dev_state_type;

   function automatic logic is_prog(input logic [7:0] op);
      return op == sfpe_pkg::OP_QUAD_PROG || op == sfpe_pkg::OP_QUAD_PROG_A4;
   endfunction

   function automatic logic is_erase(input logic [7:0] op);
      return op == sfpe_pkg::OP_ERASE_4K || op == sfpe_pkg::OP_ERASE_4K_A4 ||
             op == sfpe_pkg::OP_ERASE_32K || op == sfpe_pkg::OP_ERASE_64K ||
             op == sfpe_pkg::OP_ERASE_64K_A4;
   endfunction

   function automatic logic is_fixed_a4(input logic [7:0] op);
      return op == sfpe_pkg::OP_QUAD_PROG_A4 || op == sfpe_pkg::OP_ERASE_4K_A4 ||
             op == sfpe_pkg::OP_ERASE_64K_A4;
   endfunction

   //==========================================================
   // link side, clocked by the host's serial clock
   logic link_rst;
   logic [5:0] cnt_reg;
   logic [7:0] op_reg;
   logic [7:0] op_next;
   logic [31:0] addr_reg;
   logic [7:0] idx_reg;
   logic [3:0] hi_reg;
   logic hi_phase_reg;
   logic [7:0] stat_sh_reg;
   logic [2:0] lk_s1_reg;
   logic [2:0] lk_s2_reg;
   logic end_ok_reg;
   logic end_ok_next;
   logic [5:0] hdr_end;
   logic in_data;
   logic [7:0] page_mem [256];
   logic [255:0] loaded_reg;

   // counters restart whenever select is high, so no edge is needed
   // after the frame to tidy up
   assign link_rst = I_RST | LNK.cs_n;
   assign op_next = (cnt_reg < sfpe_pkg::OP_EDGES) ?
                    {op_reg[6:0], LNK.io[0]} : op_reg;
   assign hdr_end = sfpe_pkg::OP_EDGES + ((is_fixed_a4(op_reg) ||
                    lk_s2_reg[0]) ? sfpe_pkg::ADDR4_EDGES :
                    sfpe_pkg::ADDR3_EDGES);
   assign in_data = is_prog(op_reg) && cnt_reg >= hdr_end;

   // mode, busy and latch into the link domain
   always_ff @(posedge LNK.sck or posedge I_RST)
   begin
      if (I_RST)
      begin
         lk_s1_reg <= 3'h0;
         lk_s2_reg <= 3'h0;
      end
      else
      begin
         lk_s1_reg <= {O_WRITE_LATCH_BIT, O_BUSY, I_ADDR4_MODE};
         lk_s2_reg <= lk_s1_reg;
      end
   end

   always_ff @(posedge LNK.sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         cnt_reg <= 6'h00;
         idx_reg <= 8'h00;
         hi_reg <= 4'h0;
         hi_phase_reg <= 1'b0;
         stat_sh_reg <= 8'h00;
      end
      else
      begin
         if (cnt_reg != sfpe_pkg::EDGE_CNT_MAX)
            cnt_reg <= cnt_reg + 6'h01;
         if (cnt_reg + 6'h01 == hdr_end)
            idx_reg <= {addr_reg[6:0], LNK.io[0]};
         else if (in_data && hi_phase_reg)
            idx_reg <= idx_reg + 8'h01;
         if (in_data)
         begin
            hi_phase_reg <= ~hi_phase_reg;
            hi_reg <= LNK.io;
         end
         // status answered even while busy
         if (cnt_reg == sfpe_pkg::OP_EDGES - 6'h01 &&
             op_next == sfpe_pkg::OP_READ_STAT)
         begin
            stat_sh_reg <= 8'h00;
            stat_sh_reg[sfpe_pkg::STAT_BUSY_POS] <= lk_s2_reg[1];
            stat_sh_reg[sfpe_pkg::STAT_LATCH_POS] <= lk_s2_reg[2];
         end
         else
            stat_sh_reg <= {stat_sh_reg[6:0], 1'b0};
      end
   end

   assign LNK.dev_io_o = {2'b00, stat_sh_reg[7], 1'b0};
   assign LNK.dev_io_oe = {2'b00, cnt_reg >= sfpe_pkg::OP_EDGES &&
                           op_reg == sfpe_pkg::OP_READ_STAT, 1'b0};

   // valid end points: after the opcode for write enable, right after
   // the address for erase, on a whole data byte for program
   always_comb
   begin
      end_ok_next = 1'b0;
      if (cnt_reg == sfpe_pkg::OP_EDGES - 6'h01)
         end_ok_next = op_next == sfpe_pkg::OP_WRITE_EN;
      else if (is_erase(op_reg))
         end_ok_next = cnt_reg + 6'h01 == hdr_end;
      else if (is_prog(op_reg))
         end_ok_next = in_data && hi_phase_reg;
   end

   // frame results survive the select rise for the system side
   always_ff @(posedge LNK.sck or posedge I_RST)
   begin
      if (I_RST)
      begin
         op_reg <= 8'h00;
         addr_reg <= 32'h0;
         end_ok_reg <= 1'b0;
         loaded_reg <= '0;
      end
      else
      begin
         op_reg <= op_next;
         // cleared as the opcode completes, so a 3-byte address keeps
         // no high bits left over from an earlier frame
         if (cnt_reg == sfpe_pkg::OP_EDGES - 6'h01)
            addr_reg <= 32'h0;
         else if (cnt_reg >= sfpe_pkg::OP_EDGES && cnt_reg < hdr_end)
            addr_reg <= {addr_reg[30:0], LNK.io[0]};
         end_ok_reg <= end_ok_next;
         // cleared at the first data nibble only, so a status read during
         // a program cycle leaves the map of loaded bytes alone
         if (in_data && cnt_reg == hdr_end && !lk_s2_reg[1])
            loaded_reg <= '0;
         else if (in_data && hi_phase_reg && !lk_s2_reg[1])
            loaded_reg[idx_reg] <= 1'b1;
      end
   end

   always_ff @(posedge LNK.sck)
   begin
      if (in_data && hi_phase_reg && !lk_s2_reg[1])
         page_mem[idx_reg] <= {hi_reg, LNK.io};
   end

   //==========================================================
   // system side: select rise, checks and the self-timed cycle
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;
   logic cs_rise;
   sfpe_dev_state_type state_reg;
   logic [7:0] cmd_op_reg;
   logic [31:0] timer_reg;
   logic [8:0] wr_idx_reg;
   logic [10:0] prot_n;
   logic [10:0] blk;
   logic prot_hit;

   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end
      else
      begin
         cs_s1_reg <= LNK.cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end
   assign cs_rise = cs_s2_reg & ~cs_s3_reg;

   // range protection in 64 KB granules, top or bottom, complemented
   always_comb
   begin
      if (I_PROTECT_RANGE_BITS == 4'h0)
         prot_n = 11'h000;
      else if (I_PROTECT_RANGE_BITS > sfpe_pkg::PROT_RANGE_CAP)
         prot_n = sfpe_pkg::BLOCKS_64K;
      else
         prot_n = 11'h001 << (I_PROTECT_RANGE_BITS - 4'h1);
      blk = {1'b0, O_TARGET_ADDR[25:16]};
      prot_hit = (I_PROTECT_TOP_BOTTOM_BIT ? (blk < prot_n) :
                 (blk >= sfpe_pkg::BLOCKS_64K - prot_n)) ^
                 I_PROTECT_COMPLEMENT_BIT;
   end

   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         state_reg <= DS_IDLE;
         cmd_op_reg <= 8'h00;
         O_TARGET_ADDR <= '0;
         O_ERASE_SIZE <= sfpe_pkg::SIZE_4K;
      end
      else
      begin
         case (state_reg)
            DS_IDLE:
            begin
               // commands are only accepted here in DS_IDLE, so nothing new starts
               // while a cycle runs
               if (cs_rise && end_ok_reg && O_WRITE_LATCH_BIT &&
                   (is_erase(op_reg) || (is_prog(op_reg) &&
                   I_QUAD_IO_ENABLE_BIT)))
               begin
                  state_reg <= DS_CHECK;
                  cmd_op_reg <= op_reg;
                  case (op_reg)
                     sfpe_pkg::OP_ERASE_4K, sfpe_pkg::OP_ERASE_4K_A4:
                     begin
                        O_TARGET_ADDR <= {addr_reg[25:12], 12'h000};
                        O_ERASE_SIZE <= sfpe_pkg::SIZE_4K;
                     end
                     sfpe_pkg::OP_ERASE_32K:
                     begin
                        O_TARGET_ADDR <= {addr_reg[25:15], 15'h0000};
                        O_ERASE_SIZE <= sfpe_pkg::SIZE_32K;
                     end
                     sfpe_pkg::OP_ERASE_64K, sfpe_pkg::OP_ERASE_64K_A4:
                     begin
                        O_TARGET_ADDR <= {addr_reg[25:16], 16'h0000};
                        O_ERASE_SIZE <= sfpe_pkg::SIZE_64K;
                     end
                     default:
                        O_TARGET_ADDR <= {addr_reg[25:8], 8'h00};
                  endcase
               end
            end
            DS_CHECK:
               state_reg <= (prot_hit || I_LOCK_HIT) ? DS_IDLE : DS_RUN;
            DS_RUN:
               if (timer_reg == 32'h0)
                  state_reg <= DS_IDLE;
            default:
               state_reg <= DS_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         timer_reg <= 32'h0;
         O_BUSY <= 1'b0;
         O_REJECT <= 1'b0;
         O_ERASE_REQ <= 1'b0;
      end
      else
      begin
         O_REJECT <= state_reg == DS_CHECK && (prot_hit || I_LOCK_HIT);
         O_ERASE_REQ <= state_reg == DS_CHECK && !prot_hit && !I_LOCK_HIT &&
                        is_erase(cmd_op_reg);
         if (state_reg == DS_CHECK && !prot_hit && !I_LOCK_HIT)
         begin
            O_BUSY <= 1'b1;
            if (is_prog(cmd_op_reg))
               timer_reg <= 32'(PROG_CYCLES - 1);
            else if (O_ERASE_SIZE == sfpe_pkg::SIZE_4K)
               timer_reg <= 32'(SECTOR_CYCLES - 1);
            else if (O_ERASE_SIZE == sfpe_pkg::SIZE_32K)
               timer_reg <= 32'(HALF_BLOCK_CYCLES - 1);
            else
               timer_reg <= 32'(BLOCK_CYCLES - 1);
         end
         else if (state_reg == DS_RUN)
         begin
            if (timer_reg == 32'h0)
               O_BUSY <= 1'b0;
            else
               timer_reg <= timer_reg - 32'h1;
         end
      end
   end

   // write latch: set by write enable when idle, cleared at cycle end
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
         O_WRITE_LATCH_BIT <= 1'b0;
      else if (state_reg == DS_IDLE && cs_rise && end_ok_reg &&
               op_reg == sfpe_pkg::OP_WRITE_EN)
         O_WRITE_LATCH_BIT <= 1'b1;
      else if (state_reg == DS_RUN && timer_reg == 32'h0)
         O_WRITE_LATCH_BIT <= 1'b0;
   end

   // page buffer drains one byte a cycle at the start of the program
   // cycle; the buffer is stable because the link refuses data while
   // busy, hence the program time must exceed one page of cycles
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         wr_idx_reg <= 9'h000;
         O_PROG_WE <= 1'b0;
         O_PROG_ADDR <= '0;
         O_PROG_DATA <= 8'h00;
      end
      else
      begin
         O_PROG_WE <= 1'b0;
         if (state_reg != DS_RUN)
            wr_idx_reg <= 9'h000;
         else if (is_prog(cmd_op_reg) && wr_idx_reg < sfpe_pkg::PAGE_BYTES)
         begin
            wr_idx_reg <= wr_idx_reg + 9'h001;
            O_PROG_WE <= loaded_reg[wr_idx_reg[7:0]];
            O_PROG_ADDR <= {O_TARGET_ADDR[25:8], wr_idx_reg[7:0]};
            O_PROG_DATA <= page_mem[wr_idx_reg[7:0]];
         end
      end
   end
endmodule // sfpe_flash_dev
`default_nettype wire

// *** design/sfpe_spi_host.sv ***
// host end: frames commands onto the serial link from a command port
`timescale 1ns/10ps
`default_nettype none
module sfpe_spi_host (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic I_CMD_VALID,
   input wire logic [7:0] I_CMD_OP,
   input wire logic [31:0] I_CMD_ADDR,
   input wire logic I_CMD_ADDR4,
   input wire logic [8:0] I_CMD_NBYTES,
   input wire logic [7:0] I_WDATA,
   output logic O_CMD_READY,
   output logic O_WDATA_TAKE,
   output logic O_DONE,
   output logic [7:0] O_STATUS,
   sfpe_link_if.host LNK
);
   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP}
      sfpe_host_state_type;

   sfpe_host_state_type state_reg;
   logic [2:0] div_reg;
   logic [39:0] sh_reg;
   logic [5:0] hdr_left_reg;
   logic [9:0] data_left_reg;
   logic [3:0] rd_left_reg;
   logic [7:0] byte_reg;
   logic io1_s1_reg;
   logic io1_s2_reg;
   logic has_addr;
   logic a4;
   logic is_prog;
   logic half_end;
   logic last_bit;
   logic [10:0] left_sum;

   assign has_addr = I_CMD_OP != sfpe_pkg::OP_WRITE_EN &&
                     I_CMD_OP != sfpe_pkg::OP_READ_STAT;
   assign a4 = I_CMD_ADDR4 || I_CMD_OP == sfpe_pkg::OP_QUAD_PROG_A4 ||
               I_CMD_OP == sfpe_pkg::OP_ERASE_4K_A4 ||
               I_CMD_OP == sfpe_pkg::OP_ERASE_64K_A4;
   assign is_prog = I_CMD_OP == sfpe_pkg::OP_QUAD_PROG ||
                    I_CMD_OP == sfpe_pkg::OP_QUAD_PROG_A4;
   assign half_end = div_reg == sfpe_pkg::HOST_HALF_CYCLES - 3'h1;
   assign left_sum = {5'h00, hdr_left_reg} + {1'b0, data_left_reg} +
                     {7'h00, rd_left_reg};
   assign last_bit = left_sum == 11'h001;
   assign O_CMD_READY = state_reg == HS_IDLE;
   assign O_WDATA_TAKE = state_reg == HS_LOW && div_reg == 3'h0 &&
                         hdr_left_reg == 6'h00 && data_left_reg != 10'h000 &&
                         !data_left_reg[0];

   //==========================================================
   // status line from the device is a pin: two flops first
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         io1_s1_reg <= 1'b1;
         io1_s2_reg <= 1'b1;
      end
      else
      begin
         io1_s1_reg <= LNK.io[1];
         io1_s2_reg <= io1_s1_reg;
      end
   end

   //==========================================================
   // frame sequencer; the link clock is this clock divided down
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         state_reg <= HS_IDLE;
         div_reg <= 3'h0;
         sh_reg <= 40'h0;
         hdr_left_reg <= 6'h00;
         data_left_reg <= 10'h000;
         rd_left_reg <= 4'h0;
         byte_reg <= 8'h00;
         LNK.cs_n <= 1'b1;
         LNK.sck <= 1'b0;
         LNK.host_io_o <= 4'h0;
         LNK.host_io_oe <= 4'h0;
         O_DONE <= 1'b0;
         O_STATUS <= 8'h00;
      end
      else
      begin
         O_DONE <= 1'b0;
         div_reg <= half_end ? 3'h0 : div_reg + 3'h1;
         case (state_reg)
            HS_IDLE:
            begin
               div_reg <= 3'h0;
               if (I_CMD_VALID)
               begin
                  state_reg <= HS_LOW;
                  LNK.cs_n <= 1'b0;
                  sh_reg <= a4 ? {I_CMD_OP, I_CMD_ADDR} :
                            {I_CMD_OP, I_CMD_ADDR[23:0], 8'h00};
                  hdr_left_reg <= sfpe_pkg::OP_EDGES + (!has_addr ? 6'h00 :
                                  (a4 ? sfpe_pkg::ADDR4_EDGES :
                                  sfpe_pkg::ADDR3_EDGES));
                  data_left_reg <= is_prog ? {I_CMD_NBYTES, 1'b0} : 10'h000;
                  rd_left_reg <= (I_CMD_OP == sfpe_pkg::OP_READ_STAT) ?
                                 sfpe_pkg::STAT_EDGES : 4'h0;
               end
            end
            HS_LOW:
            begin
               if (div_reg == 3'h0)
               begin
                  if (hdr_left_reg != 6'h00)
                  begin
                     LNK.host_io_o <= {3'h0, sh_reg[39]};
                     LNK.host_io_oe <= 4'h1;
                  end
                  else if (data_left_reg != 10'h000)
                  begin
                     LNK.host_io_oe <= 4'hf;
                     if (!data_left_reg[0])
                     begin
                        byte_reg <= I_WDATA;
                        LNK.host_io_o <= I_WDATA[7:4];
                     end
                     else
                        LNK.host_io_o <= byte_reg[3:0];
                  end
                  else
                     LNK.host_io_oe <= 4'h0;
               end
               if (half_end)
               begin
                  if (hdr_left_reg == 6'h00 && data_left_reg == 10'h000)
                     O_STATUS <= {O_STATUS[6:0], io1_s2_reg};
                  LNK.sck <= 1'b1;
                  state_reg <= HS_HIGH;
               end
            end
            HS_HIGH:
               if (half_end)
               begin
                  LNK.sck <= 1'b0;
                  if (hdr_left_reg != 6'h00)
                  begin
                     hdr_left_reg <= hdr_left_reg - 6'h01;
                     sh_reg <= {sh_reg[38:0], 1'b0};
                  end
                  else if (data_left_reg != 10'h000)
                     data_left_reg <= data_left_reg - 10'h001;
                  else
                     rd_left_reg <= rd_left_reg - 4'h1;
                  if (last_bit)
                  begin
                     // select rises only after the final bit's edge
                     LNK.cs_n <= 1'b1;
                     LNK.host_io_oe <= 4'h0;
                     state_reg <= HS_GAP;
                  end
                  else
                     state_reg <= HS_LOW;
               end
            HS_GAP:
               if (half_end)
               begin
                  O_DONE <= 1'b1;
                  state_reg <= HS_IDLE;
               end
            default:
               state_reg <= HS_IDLE;
         endcase
      end
   end
endmodule // sfpe_spi_host
`default_nettype wire

// *** test/sfpe_link_chk.sv ***
// protocol checker for the serial link between host and flash ends
`timescale 1ns/10ps
`default_nettype none
module sfpe_link_chk (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] host_io_o,
   input wire logic [3:0] host_io_oe,
   input wire logic [3:0] dev_io_o,
   input wire logic [3:0] dev_io_oe,
   input wire logic [3:0] io
);
   //==========================================================
   // framing and pin ownership
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RST);
   sck_idle_a: assert property (cs_n |-> !sck)
      else $error("link clock moves while deselected");
   host_float_a: assert property (cs_n && $past(cs_n) |-> host_io_oe == 4'h0)
      else $error("host drives pins while deselected");
   dev_float_a: assert property (cs_n && $past(cs_n) |-> dev_io_oe == 4'h0)
      else $error("device drives pins while deselected");
   dev_bit1_a: assert property ({dev_io_oe[3:2], dev_io_oe[0]} == 3'h0)
      else $error("device drives a pin other than io1");
   no_clash_a: assert property ((host_io_oe & dev_io_oe) == 4'h0)
      else $error("host and device drive one pin");
   sck_half_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
      else $error("link clock high phase not four cycles");
   frame_start_a: assert property ($fell(cs_n) |-> !sck[*4])
      else $error("link clock rises too soon after select");
   bit_hold_a: assert property ($rose(sck) |-> $stable(host_io_o))
      else $error("host data changes at link clock rise");
   pin_resolve_a: assert property (io == ((host_io_oe & host_io_o) |
      (~host_io_oe & dev_io_oe & dev_io_o) | ~(host_io_oe | dev_io_oe)))
      else $error("link pin value not resolved from drivers");
   cover property ($fell(cs_n));
   cover property (dev_io_oe[1]);
   cover property ($rose(cs_n) && host_io_oe == 4'hf);
endmodule // sfpe_link_chk
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench joining host end and flash end
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic a4 = 1'b0;
   logic qe = 1'b0;
   logic lock = 1'b0;
   logic [3:0] pr_range = 4'h0;
   logic pr_bottom = 1'b0, pr_cmp = 1'b0;
   logic [7:0] op = 8'h00;
   logic [7:0] wd = 8'h10;
   logic [7:0] w0, stat, pdata, pd0;
   logic [31:0] addr = 32'h0;
   logic [8:0] nb = 9'h0;
   logic ready, take, done, busy, write_latch_bit, we, ereq, rej;
   logic [1:0] esz;
   logic [25:0] tgt, paddr, pa0, base;
   int errors = 0, n_compared = 0, cyc = 0, n_er = 0, n_we = 0;
   int n_rej = 0, nbusy = 0;
   int ops[5] = '{32'h20, 32'h21, 32'h52, 32'hd8, 32'hdc};
   int sz[5] = '{0, 0, 1, 2, 2};
   int lob[5] = '{12, 12, 15, 16, 16};
   int cy[5] = '{600, 600, 700, 800, 800};
   sfpe_link_if lnk ();
   sfpe_spi_host u_sfpe_spi_host (.I_MCLK(mclk), .I_RST(rst),
      .I_CMD_VALID(valid), .I_CMD_OP(op), .I_CMD_ADDR(addr),
      .I_CMD_ADDR4(a4), .I_CMD_NBYTES(nb), .I_WDATA(wd),
      .O_CMD_READY(ready), .O_WDATA_TAKE(take), .O_DONE(done),
      .O_STATUS(stat), .LNK(lnk.host));
   sfpe_flash_dev #(.PROG_CYCLES(300), .SECTOR_CYCLES(600),
      .HALF_BLOCK_CYCLES(700), .BLOCK_CYCLES(800)) u_sfpe_flash_dev (
      .I_MCLK(mclk), .I_RST(rst), .LNK(lnk.dev), .I_ADDR4_MODE(a4),
      .I_QUAD_IO_ENABLE_BIT(qe), .I_PROTECT_RANGE_BITS(pr_range),
      .I_PROTECT_TOP_BOTTOM_BIT(pr_bottom), .I_PROTECT_COMPLEMENT_BIT(pr_cmp),
      .I_LOCK_HIT(lock), .O_BUSY(busy), .O_WRITE_LATCH_BIT(write_latch_bit),
      .O_TARGET_ADDR(tgt), .O_PROG_WE(we), .O_PROG_ADDR(paddr),
      .O_PROG_DATA(pdata), .O_ERASE_REQ(ereq), .O_ERASE_SIZE(esz),
      .O_REJECT(rej));
   sfpe_link_chk u_sfpe_link_chk (.I_MCLK(mclk), .I_RST(rst),
      .cs_n(lnk.cs_n), .sck(lnk.sck), .host_io_o(lnk.host_io_o),
      .host_io_oe(lnk.host_io_oe), .dev_io_o(lnk.dev_io_o),
      .dev_io_oe(lnk.dev_io_oe), .io(lnk.io));
   //==========================================================
   // clock, output monitors and hang guard
   initial
   begin
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (take) wd <= wd + 8'h11;
      if (ereq) n_er <= n_er + 1;
      if (rej) n_rej <= n_rej + 1;
      nbusy <= ereq ? int'(busy) : nbusy + int'(busy);
      if (we && n_we == 0) pa0 <= paddr;
      if (we && n_we == 0) pd0 <= pdata;
      if (we) n_we <= n_we + 1;
      if (cyc == 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   //==========================================================
   // tasks
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // commands are issued after reset or after done, so ready is known high
   task automatic cmd(logic [7:0] o, logic [31:0] a, logic [8:0] n);
      op <= o;
      addr <= a;
      nb <= n;
      valid <= 1'b1;
      @(posedge mclk);
      valid <= 1'b0;
      for (int i = 0; i < 900 && done !== 1'b1; i++) @(posedge mclk);
      chk("frame done", 1, done);
   endtask
   task automatic idle();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge mclk);
      chk("busy end", 0, busy);
   endtask
   task automatic give_verdict();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   //==========================================================
   // test sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      cmd(8'h05, 0, 0);
      chk("idle status", 8'h00, stat);
      cmd(8'h20, 32'h1000, 0);
      repeat (8) @(posedge mclk);
      chk("erase without latch", 0, n_er);
      for (int k = 0; k < 5; k++)
      begin
         a4 <= (k == 2);
         cmd(8'h06, 0, 0);
         repeat (6) @(posedge mclk);
         chk("latch set", 1, write_latch_bit);
         cmd(ops[k][7:0], 32'h0123_4567, 0);
         cmd(8'h05, 0, 0);
         chk("busy status", 8'h03, stat);
         cmd(ops[k][7:0], 32'h0123_4567, 0);
         idle();
         base = (k == 0 || k == 3) ? 26'h0234567 : 26'h1234567;
         chk("erase count", k + 1, n_er);
         chk("erase size", sz[k], esz);
         chk("erase target", base >> lob[k] << lob[k], tgt);
         chk("busy length", 1, nbusy >= cy[k] && nbusy <= cy[k] + 2);
         chk("latch cleared", 0, write_latch_bit);
      end
      a4 <= 1'b0;
      cmd(8'h06, 0, 0);
      cmd(8'h32, 32'h1fe, 9'h003);
      repeat (8) @(posedge mclk);
      chk("program without quad", 0, busy);
      qe <= 1'b1;
      cmd(8'h32, 32'h1fe, 9'h000);
      repeat (8) @(posedge mclk);
      chk("empty program", 0, busy);
      w0 = wd;
      cmd(8'h34, 32'h1fe, 9'h003);
      idle();
      chk("program bytes", 3, n_we);
      chk("wrap address", 26'h100, pa0);
      chk("wrap data", w0 + 8'h22, pd0);
      lock <= 1'b1;
      cmd(8'h06, 0, 0);
      cmd(8'hd8, 32'h0, 0);
      repeat (8) @(posedge mclk);
      chk("locked refused", 1, n_rej);
      chk("locked latch kept", 1, write_latch_bit);
      lock <= 1'b0;
      pr_range <= 4'h1;
      cmd(8'h21, 32'h03ff_f000, 0);
      repeat (8) @(posedge mclk);
      chk("top block refused", 2, n_rej);
      pr_bottom <= 1'b1;
      pr_cmp <= 1'b1;
      cmd(8'h21, 32'h03ff_f000, 0);
      repeat (8) @(posedge mclk);
      chk("complement refused", 3, n_rej);
      pr_cmp <= 1'b0;
      cmd(8'h21, 32'h03ff_f000, 0);
      repeat (8) @(posedge mclk);
      chk("bottom spares top", 6, n_er);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
